// >>> hdl/bcd_seq_pkg.sv
// constants and types for the bcd weight output sequencer
package bcd_seq_pkg;
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned SPACING_MS = 10;
  localparam int unsigned SPACING_CYCLES = SPACING_MS * 1000 * CLK_MHZ;
  localparam int unsigned WEIGHT_W = 24;
  localparam int unsigned SEL_W = 6;
  localparam int unsigned SEL_GROSS = 5;
  localparam int unsigned SEL_NET = 4;
  localparam int unsigned SEL_TARE = 3;
  localparam int unsigned SEL_DISP = 2;
  localparam int unsigned SEL_PRINT = 1;
  localparam int unsigned FIFO_DEPTH = 4;
  localparam int unsigned TYPE_W = 2;
  localparam logic [1:0] TYPE_NONE = 2'h0;
  localparam logic [1:0] TYPE_GROSS = 2'h1;
  localparam logic [1:0] TYPE_NET = 2'h2;
  localparam logic [1:0] TYPE_TARE = 2'h3;
  localparam logic [31:0] CNT_RESET = 32'h0;
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'h0,
    ST_PICK = 2'h1,
    ST_WAIT = 2'h3
  } seq_state_t;
endpackage : bcd_seq_pkg

// >>> hdl/bcd_weight_output_sequencer.sv
// bcd weight output sequencer with output fifo
`timescale 1ns/1ps
module bcd_fifo #(
  parameter int unsigned WIDTH = 26,
  parameter int unsigned DEPTH = 4
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;
  always_comb
  begin
    push = in_valid && (cnt_q != (AW+1)'(DEPTH));
    pop = out_valid && out_ready;
    mem_d = mem_q;
    wr_d = wr_q;
    rd_d = rd_q;
    if (push)
    begin
      mem_d[wr_q] = in_data;
      wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
    end
    if (pop)
    begin
      rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
    end
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        mem_q[i] <= '0;
      end
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      mem_q <= mem_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end
  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
endmodule : bcd_fifo

module bcd_weight_output_sequencer #(
  parameter int unsigned SPACING_DIV = bcd_seq_pkg::SPACING_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [bcd_seq_pkg::SEL_W-1:0] output_selection_field,
  input wire logic [bcd_seq_pkg::WEIGHT_W-1:0] gross_bcd,
  input wire logic [bcd_seq_pkg::WEIGHT_W-1:0] net_bcd,
  input wire logic [bcd_seq_pkg::WEIGHT_W-1:0] tare_bcd,
  input wire logic [bcd_seq_pkg::TYPE_W-1:0] display_type,
  input wire logic print_req,
  input wire logic trigger_req,
  output logic [bcd_seq_pkg::WEIGHT_W-1:0] bcd_data,
  output logic [bcd_seq_pkg::TYPE_W-1:0] weight_type,
  output logic data_valid,
  input wire logic data_ready,
  output logic busy
);
  localparam int unsigned FW = bcd_seq_pkg::WEIGHT_W + bcd_seq_pkg::TYPE_W;
  bcd_seq_pkg::seq_state_t st_q, st_d;
  logic print_q, trig_q, print_d, trig_d;
  logic [2:0] pend_q, pend_d;
  logic [31:0] cnt_q, cnt_d;
  logic [FW-1:0] push_data, fifo_out;
  logic push_valid, push_ready, fifo_valid, pop_ready;
  logic [FW-1:0] out_q, out_d;
  logic out_v_q, out_v_d;
  logic [2:0] en_mask;
  logic req_edge;
  logic [1:0] pick_type;

  // weight value for a type code
  function automatic logic [bcd_seq_pkg::WEIGHT_W-1:0] value_of(
    input logic [1:0] t,
    input logic [bcd_seq_pkg::WEIGHT_W-1:0] g,
    input logic [bcd_seq_pkg::WEIGHT_W-1:0] n,
    input logic [bcd_seq_pkg::WEIGHT_W-1:0] r
  );
    case (t)
      bcd_seq_pkg::TYPE_GROSS: value_of = g;
      bcd_seq_pkg::TYPE_NET: value_of = n;
      bcd_seq_pkg::TYPE_TARE: value_of = r;
      default: value_of = '0;
    endcase
  endfunction : value_of

  localparam logic [31:0] CNT_ONE = 32'h1;

  always_comb
  begin
    print_d = print_req;
    trig_d = trigger_req;
    en_mask = {output_selection_field[bcd_seq_pkg::SEL_GROSS],
               output_selection_field[bcd_seq_pkg::SEL_NET],
               output_selection_field[bcd_seq_pkg::SEL_TARE]};
    req_edge = (trigger_req && !trig_q) ||
               (print_req && !print_q && output_selection_field[bcd_seq_pkg::SEL_PRINT]);
    if (pend_q[2])
    begin
      pick_type = bcd_seq_pkg::TYPE_GROSS;
    end
    else if (pend_q[1])
    begin
      pick_type = bcd_seq_pkg::TYPE_NET;
    end
    else
    begin
      pick_type = bcd_seq_pkg::TYPE_TARE;
    end
    st_d = st_q;
    pend_d = pend_q;
    cnt_d = cnt_q;
    push_valid = 1'b0;
    push_data = '0;
    case (st_q)
      bcd_seq_pkg::ST_IDLE:
      begin
        if (req_edge)
        begin
          if (output_selection_field[bcd_seq_pkg::SEL_DISP])
          begin
            pend_d = (display_type == bcd_seq_pkg::TYPE_GROSS) ? 3'h4 :
                     (display_type == bcd_seq_pkg::TYPE_NET) ? 3'h2 :
                     (display_type == bcd_seq_pkg::TYPE_TARE) ? 3'h1 : 3'h0;
          end
          else
          begin
            pend_d = en_mask;
          end
          st_d = bcd_seq_pkg::ST_PICK;
        end
      end
      bcd_seq_pkg::ST_PICK:
      begin
        if (pend_q == 3'h0)
        begin
          st_d = bcd_seq_pkg::ST_IDLE;
        end
        else
        begin
          push_valid = 1'b1;
          push_data = {pick_type, value_of(pick_type, gross_bcd, net_bcd, tare_bcd)};
          if (push_ready)
          begin
            pend_d = pend_q & ~((pick_type == bcd_seq_pkg::TYPE_GROSS) ? 3'h4 :
                     (pick_type == bcd_seq_pkg::TYPE_NET) ? 3'h2 : 3'h1);
            cnt_d = CNT_ONE;
            st_d = bcd_seq_pkg::ST_WAIT;
          end
        end
      end
      bcd_seq_pkg::ST_WAIT:
      begin
        if (pend_q == 3'h0)
        begin
          st_d = bcd_seq_pkg::ST_IDLE;
        end
        else if (cnt_q >= SPACING_DIV - 1)
        begin
          st_d = bcd_seq_pkg::ST_PICK;
        end
        else
        begin
          cnt_d = cnt_q + 32'h1;
        end
      end
      default:
      begin
        st_d = bcd_seq_pkg::ST_IDLE;
      end
    endcase
    pop_ready = !out_v_q || data_ready;
    out_d = out_q;
    out_v_d = out_v_q;
    if (pop_ready)
    begin
      out_v_d = fifo_valid;
      if (fifo_valid)
      begin
        out_d = fifo_out;
      end
    end
  end

  bcd_fifo #(
    .WIDTH(FW),
    .DEPTH(bcd_seq_pkg::FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .in_data(push_data),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .out_data(fifo_out),
    .out_valid(fifo_valid),
    .out_ready(pop_ready)
  );

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_q <= bcd_seq_pkg::ST_IDLE;
      print_q <= 1'b0;
      trig_q <= 1'b0;
      pend_q <= 3'h0;
      cnt_q <= bcd_seq_pkg::CNT_RESET;
      out_q <= '0;
      out_v_q <= 1'b0;
      busy <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      print_q <= print_d;
      trig_q <= trig_d;
      pend_q <= pend_d;
      cnt_q <= cnt_d;
      out_q <= out_d;
      out_v_q <= out_v_d;
      busy <= (st_d != bcd_seq_pkg::ST_IDLE);
    end
  end

  assign bcd_data = out_q[bcd_seq_pkg::WEIGHT_W-1:0];
  assign weight_type = out_q[FW-1:bcd_seq_pkg::WEIGHT_W];
  assign data_valid = out_v_q;
endmodule : bcd_weight_output_sequencer

// >>> verif/bcd_receiver_model.sv
// bcd receiving equipment that stalls two cycles in eight
`timescale 1ns/1ps
module bcd_receiver_model (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic data_valid,
  output logic data_ready
);
  logic [2:0] cnt_q;
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b) cnt_q <= 3'h0;
    else cnt_q <= cnt_q + 3'h1;
  end
  assign data_ready = cnt_q[2:1] != 2'h0;
endmodule : bcd_receiver_model

// >>> verif/bcd_seq_props.sv
// assertion checker for the bcd weight output sequencer
`timescale 1ns/1ps
module bcd_seq_props #(
  parameter int unsigned SPACING_DIV = 20
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [bcd_seq_pkg::SEL_W-1:0] output_selection_field,
  input wire logic [bcd_seq_pkg::WEIGHT_W-1:0] gross_bcd,
  input wire logic [bcd_seq_pkg::WEIGHT_W-1:0] net_bcd,
  input wire logic [bcd_seq_pkg::WEIGHT_W-1:0] tare_bcd,
  input wire logic [bcd_seq_pkg::TYPE_W-1:0] display_type,
  input wire logic print_req,
  input wire logic trigger_req,
  input wire logic [bcd_seq_pkg::WEIGHT_W-1:0] bcd_data,
  input wire logic [bcd_seq_pkg::TYPE_W-1:0] weight_type,
  input wire logic data_valid,
  input wire logic data_ready,
  input wire logic busy
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence s_go;
    !busy && !data_valid && $rose(trigger_req);
  endsequence
  a_type_coded: assert property (data_valid |-> weight_type != bcd_seq_pkg::TYPE_NONE)
    else $error("value without type");
  a_hold_stall: assert property (data_valid && !data_ready |=> data_valid && $stable(bcd_data)
    && $stable(weight_type)) else $error("word changed while stalled");
  a_trig_start: assert property (!busy && $rose(trigger_req) |-> ##[1:2] busy)
    else $error("trigger not taken");
  a_print_gate: assert property (!busy && $rose(print_req) && !output_selection_field[1]
    && !trigger_req |=> !busy[*3]) else $error("print taken while disabled");
  a_gross_first: assert property (s_go ##0 (output_selection_field[5]
    && !output_selection_field[2]) |-> ##[1:5] (data_valid
    && weight_type == bcd_seq_pkg::TYPE_GROSS && bcd_data == gross_bcd))
    else $error("gross not sent first");
  a_net_value: assert property (s_go ##0 (output_selection_field[5:2] == 4'h4)
    |-> ##[1:5] (data_valid && weight_type == bcd_seq_pkg::TYPE_NET && bcd_data == net_bcd))
    else $error("net value wrong");
  a_disp_follow: assert property (s_go ##0 (output_selection_field[2] && display_type != 0)
    |-> ##[1:5] (data_valid && weight_type == display_type)) else $error("display type not sent");
  a_value_gap: assert property (data_valid && data_ready && busy |=> !data_valid[*8])
    else $error("values too close");
  cover property (s_go ##0 output_selection_field[5:3] == 3'h7);
  cover property (data_valid && !data_ready);
  cover property (busy && $rose(trigger_req));
endmodule : bcd_seq_props
bind bcd_weight_output_sequencer bcd_seq_props #(.SPACING_DIV(SPACING_DIV)) u_props (
  .sys_clk(sys_clk), .rst_b(rst_b), .output_selection_field(output_selection_field),
  .gross_bcd(gross_bcd), .net_bcd(net_bcd), .tare_bcd(tare_bcd), .display_type(display_type),
  .print_req(print_req), .trigger_req(trigger_req), .bcd_data(bcd_data),
  .weight_type(weight_type), .data_valid(data_valid), .data_ready(data_ready), .busy(busy));

// >>> verif/tb_bcd_weight_output_sequencer.sv
// self-checking bench for the bcd weight output sequencer
`timescale 1ns/1ps
module tb_bcd_weight_output_sequencer;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [5:0] sel = 6'h00;
  logic [23:0] g = 24'h0, n = 24'h0, r = 24'h0, bcd_data;
  logic [1:0] disp = 2'h0, weight_type;
  logic pr = 1'b0, tr = 1'b0, data_valid, data_ready, busy;
  logic [15:0] seed = 16'h2B87;
  logic [25:0] exp_q[$];
  int error_cnt = 0, checks_done = 0;
  localparam int unsigned GAP = 20;
  always #2 sys_clk = ~sys_clk;
  bcd_weight_output_sequencer #(.SPACING_DIV(GAP)) DUT (.sys_clk(sys_clk), .rst_b(rst_b),
    .output_selection_field(sel), .gross_bcd(g), .net_bcd(n), .tare_bcd(r),
    .display_type(disp), .print_req(pr), .trigger_req(tr), .bcd_data(bcd_data),
    .weight_type(weight_type), .data_valid(data_valid), .data_ready(data_ready), .busy(busy));
  bcd_receiver_model u_rx (.sys_clk(sys_clk), .rst_b(rst_b), .data_valid(data_valid),
    .data_ready(data_ready));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic void plan(input logic [5:0] s, input logic p);
    if (p && !s[1]) return;
    if (s[2])
    begin
      if (disp != 2'h0) exp_q.push_back({disp, disp == 2'h1 ? g : disp == 2'h2 ? n : r});
    end
    else
    begin
      if (s[5]) exp_q.push_back({bcd_seq_pkg::TYPE_GROSS, g});
      if (s[4]) exp_q.push_back({bcd_seq_pkg::TYPE_NET, n});
      if (s[3]) exp_q.push_back({bcd_seq_pkg::TYPE_TARE, r});
    end
  endfunction : plan
  task automatic chk(input logic [25:0] seen, input logic [25:0] want);
    checks_done++;
    if (seen !== want)
    begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
    end
  endtask : chk
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up
  always @(posedge sys_clk)
    if (rst_b && data_valid && data_ready)
      chk({weight_type, bcd_data}, exp_q.size() ? exp_q.pop_front() : 26'h3FFFFFF);
  task automatic run_op(input logic [5:0] s, input logic p);
    int k, t_rise;
    logic dv_was;
    @(posedge sys_clk);
    sel <= s;
    g <= {seed, seed[7:0]};
    n <= {seed[7:0], seed};
    r <= {seed[11:0], seed[15:4]};
    @(posedge sys_clk);
    plan(s, p);
    if (p) pr <= 1'b1;
    else tr <= 1'b1;
    @(posedge sys_clk);
    pr <= 1'b0;
    tr <= 1'b0;
    repeat (2) @(posedge sys_clk);
    tr <= exp_q.size() > 1;
    @(posedge sys_clk);
    tr <= 1'b0;
    k = 0;
    t_rise = -1;
    dv_was = 1'b1;
    while ((busy || data_valid || exp_q.size() != 0) && k < 500)
    begin
      @(posedge sys_clk);
      k++;
      if (data_valid && !dv_was && t_rise >= 0) chk(26'(k - t_rise), 26'(GAP));
      if (data_valid && !dv_was) t_rise = k;
      dv_was = data_valid;
    end
    chk(26'(exp_q.size()), 26'h0);
    chk(26'(k >= 500), 26'h0);
    repeat (4) @(posedge sys_clk);
  endtask : run_op
  initial
  begin
    #200000;
    error_cnt++;
    wrap_up();
  end
  initial
  begin
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge sys_clk);
    run_op(6'h3A, 1'b0);
    run_op(6'h3B, 1'b1);
    run_op(6'h38, 1'b1);
    run_op(6'h00, 1'b0);
    run_op(6'h10, 1'b0);
    disp <= 2'h2;
    run_op(6'h3C, 1'b0);
    for (int i = 0; i < 24; i++)
    begin
      seed = lfsr(seed);
      disp <= seed[9:8];
      run_op(seed[5:0], seed[6]);
    end
    wrap_up();
  end
endmodule : tb_bcd_weight_output_sequencer
